/* pkg/scf_pkg.sv */
// Behaviour
// - device shifts data out only while selected
// - serial output changes only on clock fall
// - serial input sampled on clock rise
// - deselected device floats its serial output
// - select low enables device, accepts clocking
// - nothing happens before first select fall
// - one select low period frames one instruction
// - master alone generates the serial clock
// - master captures output on following rise
// - master sends program data on serial input
// - capacity 1 or 4 Mbit, all reachable
// - array starts erased, reads all ones
// - instruction, address in, then data out
package scf_pkg;
  // system clock and link timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_HALF_NS = 160;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_HIGH_NS = 100;
  localparam int SEL_HIGH_CYC = (SEL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  // array capacities of the two density variants
  localparam int CAP_SMALL_BITS = 1048576;
  localparam int CAP_LARGE_BITS = 4194304;
  // frame layout
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 24;
  localparam int LEN_W = 16;
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  // instruction codes
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_PROG = 8'h02;
  // erased cell value
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // read data buffer in the master
  localparam int FIFO_DEPTH = 4;
endpackage : scf_pkg

/* pkg/scf_if.sv */
`timescale 1ns/100ps
// four-wire link between the flash end and the master end
interface scf_if;
  logic serial_clock; // driven by master only
  logic sel_n; // active-low select
  logic serial_data_in; // master to flash
  logic dev_dout; // flash output value
  logic dev_oe; // flash output enable
  logic master_serial_in; // resolved data wire, pulled high when floating
  assign master_serial_in = dev_oe ? dev_dout : 1'b1;
  modport dev (
    input serial_clock,
    input sel_n,
    input serial_data_in,
    output dev_dout,
    output dev_oe
  );
  modport mst (
    output serial_clock,
    output sel_n,
    output serial_data_in,
    input master_serial_in
  );
endinterface : scf_if

/* hw/scf_flash_dev.sv */
`timescale 1ns/100ps
// flash end: samples the link with its own clock, serves read and program
module scf_flash_dev #(
  parameter int MEM_BITS = scf_pkg::CAP_SMALL_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  scf_if.dev link,
  // user side status
  output logic dev_active,
  output logic dev_armed
);
  import scf_pkg::*;

  localparam int MEM_BYTES = MEM_BITS / BYTE_W;
  localparam int AW = $clog2(MEM_BYTES);

  // frame phase
  typedef enum logic [2:0] {
    SCF_PH_CMD,
    SCF_PH_ADDR,
    SCF_PH_READ,
    SCF_PH_PROG,
    SCF_PH_SKIP
  } scf_phase_t;

  // all state of the flash end
  typedef struct packed {
    logic [1:0] clk_s; // clock synchroniser
    logic clk_q; // previous synced clock
    logic [1:0] sel_s; // select synchroniser
    logic sel_q; // previous synced select
    logic [1:0] sdi_s; // data synchroniser
    logic armed; // first select fall seen
    logic active; // inside a frame
    scf_phase_t phase; // frame phase
    logic [2:0] bit_cnt; // bit in byte
    logic [7:0] shift; // input shifter
    logic [1:0] addr_idx; // address byte index
    logic [7:0] cmd; // instruction of frame
    logic [ADDR_W-1:0] addr; // current address
    logic dout; // output bit
    logic oe; // output enable
  } scf_dev_st_t;

  // select history starts low, so a select held low through reset never looks like a fall
  localparam scf_dev_st_t RST_ST = '{
    clk_s: 2'h0, clk_q: 1'b0, sel_s: 2'h0, sel_q: 1'b0, sdi_s: 2'h0,
    armed: 1'b0, active: 1'b0, phase: SCF_PH_CMD, bit_cnt: BIT_FIRST,
    shift: 8'h00, addr_idx: 2'h0, cmd: 8'h00, addr: '0, dout: 1'b0,
    oe: 1'b0
  };

  scf_dev_st_t st_reg; // registered state
  scf_dev_st_t st_next; // next state
  // storage array, delivered erased
  logic [7:0] mem [MEM_BYTES] = '{default: ERASED_BYTE};
  logic prog_en; // program strobe
  logic [AW-1:0] prog_addr; // program address
  logic [7:0] prog_data; // program value
  logic [7:0] rd_byte; // byte at current address

  // current byte, low address bits wrap over the whole array
  assign rd_byte = mem[st_reg.addr[AW-1:0]];

  // synced link edges
  logic clk_rise; // serial clock rising
  logic clk_fall; // serial clock falling
  logic sel_fall; // select falling
  logic sel_high; // select high
  logic [7:0] in_byte; // byte with newest bit
  assign clk_rise = st_reg.clk_s[1] & ~st_reg.clk_q;
  assign clk_fall = ~st_reg.clk_s[1] & st_reg.clk_q;
  assign sel_fall = ~st_reg.sel_s[1] & st_reg.sel_q;
  assign sel_high = st_reg.sel_s[1];
  assign in_byte = {st_reg.shift[6:0], st_reg.sdi_s[1]};

  // next state of the frame decoder
  always_comb begin
    st_next = st_reg;
    prog_en = 1'b0;
    prog_addr = st_reg.addr[AW-1:0];
    prog_data = in_byte;
    // second stage only reads first stage
    st_next.clk_s = {st_reg.clk_s[0], link.serial_clock};
    st_next.sel_s = {st_reg.sel_s[0], link.sel_n};
    st_next.sdi_s = {st_reg.sdi_s[0], link.serial_data_in};
    st_next.clk_q = st_reg.clk_s[1];
    st_next.sel_q = st_reg.sel_s[1];
    if (sel_high) begin
      // deselected: float output, drop any partial byte
      st_next.oe = 1'b0;
      st_next.active = 1'b0;
      st_next.phase = SCF_PH_CMD;
      st_next.bit_cnt = BIT_FIRST;
    end else if (sel_fall) begin
      // select fall arms the part and opens a frame
      st_next.armed = 1'b1;
      st_next.active = 1'b1;
      st_next.phase = SCF_PH_CMD;
      st_next.bit_cnt = BIT_FIRST;
      st_next.addr_idx = 2'h0;
    end else if (st_reg.active && st_reg.armed) begin
      if (clk_rise) begin
        // input sampled on rising edges
        st_next.shift = in_byte;
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        if (st_reg.bit_cnt == BIT_LAST) begin
          unique case (st_reg.phase)
            SCF_PH_CMD: begin
              // instruction byte chooses the frame type
              st_next.cmd = in_byte;
              st_next.addr_idx = 2'h0;
              if (in_byte == CMD_READ || in_byte == CMD_PROG) begin
                st_next.phase = SCF_PH_ADDR;
              end else begin
                st_next.phase = SCF_PH_SKIP;
              end
            end
            SCF_PH_ADDR: begin
              // three address bytes, high byte first
              st_next.addr = {st_reg.addr[ADDR_W-BYTE_W-1:0], in_byte};
              st_next.addr_idx = st_reg.addr_idx + 2'h1;
              if (st_reg.addr_idx == ADDR_LAST) begin
                if (st_reg.cmd == CMD_READ) begin
                  st_next.phase = SCF_PH_READ;
                end else begin
                  st_next.phase = SCF_PH_PROG;
                end
              end
            end
            SCF_PH_PROG: begin
              // program received byte, then step address
              prog_en = 1'b1;
              st_next.addr = st_reg.addr + ADDR_W'(1);
            end
            SCF_PH_READ: begin
              // last bit of byte shown, move to next byte
              st_next.addr = st_reg.addr + ADDR_W'(1);
            end
            SCF_PH_SKIP: begin
              // unknown instruction: ignore rest of frame
              st_next.phase = SCF_PH_SKIP;
            end
          endcase
        end
      end else if (clk_fall && st_reg.phase == SCF_PH_READ) begin
        // output moves only on falling edges, msb first
        st_next.dout = rd_byte[BIT_LAST - st_reg.bit_cnt];
        st_next.oe = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= RST_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  // programming can only clear bits of a cell
  always_ff @(posedge clk) begin
    if (rst_n && prog_en) begin
      mem[prog_addr] <= mem[prog_addr] & prog_data;
    end
  end

  // link and status outputs straight from the state register
  assign link.dev_dout = st_reg.dout;
  assign link.dev_oe = st_reg.oe;
  assign dev_active = st_reg.active;
  assign dev_armed = st_reg.armed;
endmodule : scf_flash_dev

/* hw/scf_master.sv */
`timescale 1ns/100ps
// small first-in first-out buffer for read data
module scf_fifo #(
  parameter int W = scf_pkg::BYTE_W,
  parameter int DEPTH = scf_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import scf_pkg::*;
  localparam int PW = $clog2(DEPTH);
  // pointers and fill level
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } scf_fifo_st_t;
  scf_fifo_st_t st_reg; // registered pointers
  scf_fifo_st_t st_next; // next pointers
  logic [W-1:0] mem [DEPTH]; // storage
  logic push; // accepted write
  logic pop; // accepted read
  assign in_ready = st_reg.cnt != (PW+1)'(DEPTH);
  assign out_valid = st_reg.cnt != '0;
  assign out_data = mem[st_reg.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // pointer update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + PW'(1);
    end
    if (pop) begin
      st_next.rp = st_reg.rp + PW'(1);
    end
    st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end
  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // data store
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wp] <= in_data;
    end
  end
endmodule : scf_fifo

// master end: makes the serial clock, frames read and program requests
module scf_master (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  scf_if.mst link,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_prog,
  input wire logic [scf_pkg::ADDR_W-1:0] req_addr,
  input wire logic [scf_pkg::LEN_W-1:0] req_len,
  // program data
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [scf_pkg::BYTE_W-1:0] wr_data,
  // read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [scf_pkg::BYTE_W-1:0] rd_data
);
  import scf_pkg::*;

  // master states
  typedef enum logic [2:0] {
    SCF_M_IDLE, SCF_M_HDR, SCF_M_WGET, SCF_M_WDATA, SCF_M_RDATA, SCF_M_DESEL
  } scf_mstate_t;

  // all state of the master end
  typedef struct packed {
    scf_mstate_t st;
    logic [1:0] din_s; // data synchroniser
    logic sclk; // serial clock out
    logic sel_n; // select out
    logic sdi; // serial data out
    logic [DIV_W-1:0] div; // half-period counter
    logic [2:0] bit_cnt; // bit in byte
    logic [1:0] hdr_idx; // header byte index
    logic [7:0] tx; // byte being sent
    logic [6:0] rx; // bits being received
    logic prog; // frame programs
    logic [ADDR_W-1:0] addr; // start address
    logic [LEN_W-1:0] remain; // data bytes left
    logic req_ready; // request accept
    logic wr_ready; // program byte accept
  } scf_mst_st_t;

  localparam scf_mst_st_t RST_ST = '{
    st: SCF_M_IDLE, din_s: 2'h3, sclk: 1'b0, sel_n: 1'b1, sdi: 1'b0, div: '0,
    bit_cnt: BIT_FIRST, hdr_idx: 2'h0, tx: 8'h00, rx: 7'h00, prog: 1'b0,
    addr: '0, remain: '0, req_ready: 1'b0, wr_ready: 1'b0
  };

  // header byte by index: instruction then address high to low
  function automatic logic [7:0] hdr_byte(input logic [1:0] idx,
      input logic prog, input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    unique case (idx)
      2'h0: b = prog ? CMD_PROG : CMD_READ;
      2'h1: b = a[ADDR_W-1 -: BYTE_W];
      2'h2: b = a[ADDR_W-BYTE_W-1 -: BYTE_W];
      default: b = a[BYTE_W-1:0];
    endcase
    return b;
  endfunction : hdr_byte

  scf_mst_st_t r; // registered state
  scf_mst_st_t n; // next state
  logic tick; // half period elapsed
  logic shifting; // clocking a byte
  logic push; // read byte complete
  logic fifo_in_ready; // buffer has room
  logic [7:0] rx_byte; // byte with newest bit
  assign tick = r.div == DIV_W'(SCLK_HALF_CYC - 1);
  assign shifting = r.st == SCF_M_HDR || r.st == SCF_M_WDATA || r.st == SCF_M_RDATA;
  assign rx_byte = {r.rx, r.din_s[1]};

  // next state
  always_comb begin
    n = r;
    push = 1'b0;
    n.din_s = {r.din_s[0], link.master_serial_in};
    n.div = tick ? '0 : r.div + DIV_W'(1);
    unique case (r.st)
      SCF_M_IDLE: begin
        // wait for request, select stays high
        n.div = '0;
        n.req_ready = 1'b1;
        if (req_valid && r.req_ready) begin
          n.req_ready = 1'b0;
          n.prog = req_prog;
          n.addr = req_addr;
          n.remain = req_len;
          n.hdr_idx = 2'h0;
          n.bit_cnt = BIT_FIRST;
          n.tx = hdr_byte(2'h0, req_prog, req_addr);
          n.sdi = n.tx[BIT_LAST];
          n.sel_n = 1'b0;
          n.st = SCF_M_HDR;
        end
      end
      SCF_M_WGET: begin
        // clock parked low until program byte arrives
        n.div = '0;
        n.wr_ready = 1'b1;
        if (wr_valid && r.wr_ready) begin
          n.wr_ready = 1'b0;
          n.tx = wr_data;
          n.sdi = wr_data[BIT_LAST];
          n.st = SCF_M_WDATA;
        end
      end
      SCF_M_DESEL: begin
        // keep select high for its minimum time
        n.sel_n = 1'b1;
        n.sdi = 1'b0;
        if (r.div == DIV_W'(SEL_HIGH_CYC - 1)) begin
          n.st = SCF_M_IDLE;
          n.req_ready = 1'b1;
        end
      end
      default: begin
        if (tick && !r.sclk) begin
          if (r.st == SCF_M_RDATA && r.bit_cnt == BIT_FIRST && !fifo_in_ready) begin
            // no room for another byte: hold the clock low
            n.div = r.div;
          end else begin
            // rising edge: capture device output
            n.sclk = 1'b1;
            n.rx = rx_byte[6:0];
            n.bit_cnt = r.bit_cnt + 3'h1;
            if (r.st == SCF_M_RDATA && r.bit_cnt == BIT_LAST) begin
              push = 1'b1;
              n.remain = r.remain - LEN_W'(1);
            end
          end
        end else if (tick && r.sclk) begin
          // falling edge: present next bit or end byte
          n.sclk = 1'b0;
          n.sdi = r.tx[BIT_LAST - r.bit_cnt];
          if (r.bit_cnt == BIT_FIRST) begin
            if (r.st == SCF_M_HDR && r.hdr_idx != HDR_LAST) begin
              n.hdr_idx = r.hdr_idx + 2'h1;
              n.tx = hdr_byte(n.hdr_idx, r.prog, r.addr);
              n.sdi = n.tx[BIT_LAST];
            end else begin
              if (r.st == SCF_M_WDATA) begin
                n.remain = r.remain - LEN_W'(1);
              end
              if (n.remain == '0) begin
                n.st = SCF_M_DESEL;
                n.div = '0;
              end else if (r.prog) begin
                n.st = SCF_M_WGET;
              end else begin
                n.st = SCF_M_RDATA;
              end
            end
          end
        end
      end
    endcase
    if (!shifting && r.st != SCF_M_DESEL) begin
      n.sclk = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= RST_ST;
    end else begin
      r <= n;
    end
  end

  // read data passes through the buffer
  scf_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx_byte),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // link and handshake outputs from the state register
  assign link.serial_clock = r.sclk;
  assign link.sel_n = r.sel_n;
  assign link.serial_data_in = r.sdi;
  assign req_ready = r.req_ready;
  assign wr_ready = r.wr_ready;
endmodule : scf_master

/* bench/scf_link_monitor.sv */
`timescale 1ns/100ps
// watches the link between master end and flash end for framing and timing slips
module scf_link_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link wires
  input wire logic serial_clock,
  input wire logic sel_n,
  input wire logic serial_data_in,
  input wire logic dev_dout,
  input wire logic dev_oe
);
  import scf_pkg::*;

  // helper state, one record
  typedef struct packed {
    logic sck; // serial clock one cycle ago
    logic [5:0] rises; // rises in this frame, saturating
    logic [7:0] shift; // last eight bits taken at rises
    logic [3:0] low; // cycles since the clock went low, saturating
  } scf_mon_t;

  scf_mon_t st_reg; // registered helper state
  scf_mon_t st_next; // next helper state

  // count rises, collect bits, time the low phase
  always_comb begin
    st_next = st_reg;
    st_next.sck = serial_clock;
    if (sel_n) begin
      // deselected: frame counters restart
      st_next.rises = 6'h00;
      st_next.shift = 8'h00;
    end else if (serial_clock && !st_reg.sck) begin
      // rising edge inside a frame
      if (st_reg.rises != 6'h3F) begin
        st_next.rises = st_reg.rises + 6'h01;
      end
      st_next.shift = {st_reg.shift[6:0], serial_data_in};
    end
    if (serial_clock) begin
      st_next.low = 4'h0;
    end else if (st_reg.low != 4'hF) begin
      st_next.low = st_reg.low + 4'h1;
    end
  end

  // register the helper state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // clock high for exactly one half period, then low
  sequence s_high_phase;
    serial_clock [*8] ##1 !serial_clock;
  endsequence
  // data line held while the far end samples it
  sequence s_sdi_held;
    $stable(serial_data_in) [*4];
  endsequence
  // minimum select-high gap between frames
  sequence s_sel_gap;
    sel_n [*5];
  endsequence

  a_oe_off_desel: assert property (sel_n [*6] |-> !dev_oe)
    else $error("flash drives its output while deselected");
  a_dout_after_fall: assert property (
    dev_oe && $past(dev_oe) && $changed(dev_dout) |-> !serial_clock && st_reg.low <= 4'h6)
    else $error("flash output moved away from a clock fall");
  a_cmd_byte_legal: assert property (
    $changed(st_reg.rises) && st_reg.rises == 6'h08
    |-> st_reg.shift == CMD_READ || st_reg.shift == CMD_PROG)
    else $error("first byte of frame is not a known instruction");
  a_out_after_header: assert property ($rose(dev_oe) |-> !sel_n && st_reg.rises >= 6'h20)
    else $error("flash output enabled before the header was complete");
  a_sdi_hold_rise: assert property ($rose(serial_clock) |-> s_sdi_held)
    else $error("serial data in changed around a clock rise");
  a_clk_idle_desel: assert property (sel_n |-> !serial_clock)
    else $error("serial clock high outside a frame");
  a_sel_high_gap: assert property ($rose(sel_n) |-> s_sel_gap)
    else $error("select high time too short");
  a_sck_half_period: assert property ($rose(serial_clock) |-> s_high_phase)
    else $error("serial clock high phase has wrong length");

  // a read data phase was reached
  c_read_phase: cover property ($rose(dev_oe));
endmodule : scf_link_monitor

/* bench/tb_top.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
// both ends joined on link_a; a second flash end on link_b is driven by the bench
module tb_top;
  import scf_pkg::*;
  localparam int MEM_B = CAP_SMALL_BITS; // small density variant
  localparam int TOP_A = MEM_B / 8 - 1; // last byte address of the array
  localparam logic [47:0] EXP6 = 48'hA03CFFFFFFFF; // bytes from 0x100 on
  // clock, reset, counters
  logic clk;
  logic rst_n;
  int errors;
  int total_checks;
  // master user side
  logic req_valid, req_ready, req_prog, wr_valid, wr_ready, rd_valid, rd_ready;
  logic [ADDR_W-1:0] req_addr;
  logic [LEN_W-1:0] req_len;
  logic [BYTE_W-1:0] wr_data, rd_data, q;
  logic oe, b_active, b_armed;

  scf_if link_a();
  scf_if link_b();

  scf_flash_dev #(.MEM_BITS(MEM_B)) scf_flash_dev_i (.clk(clk), .rst_n(rst_n),
    .link(link_a.dev), .dev_active(), .dev_armed());
  scf_flash_dev #(.MEM_BITS(MEM_B)) scf_flash_dev_b_i (.clk(clk), .rst_n(rst_n),
    .link(link_b.dev), .dev_active(b_active), .dev_armed(b_armed));
  scf_master scf_master_i (.clk(clk), .rst_n(rst_n), .link(link_a.mst),
    .req_valid(req_valid), .req_ready(req_ready), .req_prog(req_prog),
    .req_addr(req_addr), .req_len(req_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  scf_link_monitor scf_link_monitor_i (.clk(clk), .rst_n(rst_n),
    .serial_clock(link_a.serial_clock), .sel_n(link_a.sel_n),
    .serial_data_in(link_a.serial_data_in), .dev_dout(link_a.dev_dout),
    .dev_oe(link_a.dev_oe));

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // hand one request to the master, held until taken
  task automatic m_req(input logic p, input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n);
    int k;
    tick(1);
    req_valid = 1'h1;
    req_prog = p;
    req_addr = a;
    req_len = n;
    // ready is read where it has settled; the edge after that takes the request
    k = 0;
    while (req_ready !== 1'h1 && k < 5000) begin
      tick(1);
      k++;
    end
    if (k >= 5000) errors++;
    tick(1);
    req_valid = 1'h0;
  endtask : m_req

  // hand one program byte to the master
  task automatic m_write(input logic [BYTE_W-1:0] d);
    int k;
    tick(1);
    wr_valid = 1'h1;
    wr_data = d;
    // byte held until the edge after ready is seen settled high
    k = 0;
    while (wr_ready !== 1'h1 && k < 5000) begin
      tick(1);
      k++;
    end
    if (k >= 5000) errors++;
    tick(1);
    wr_valid = 1'h0;
  endtask : m_write

  // take one read byte and compare it
  task automatic m_read(input logic [BYTE_W-1:0] exp);
    int k;
    logic [BYTE_W-1:0] got;
    tick(1);
    rd_ready = 1'h1;
    k = 0;
    while (rd_valid !== 1'h1 && k < 5000) begin
      tick(1);
      k++;
    end
    // data that stands before the popping edge
    got = rd_data;
    if (k >= 5000) errors++;
    tick(1);
    rd_ready = 1'h0;
    `CHK(got, exp)
  endtask : m_read

  // one bit on link_b: data set while low, sampled late in the high phase
  task automatic b_bit(input logic d, output logic r);
    link_b.serial_data_in = d;
    tick(4);
    link_b.serial_clock = 1'h1;
    tick(4);
    r = link_b.master_serial_in;
    link_b.serial_clock = 1'h0;
  endtask : b_bit

  // one byte on link_b, msb first
  task automatic b_byte(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) b_bit(d[i], r[i]);
  endtask : b_byte

  // open and close a frame on link_b; clock stands low between frames
  task automatic b_open();
    link_b.sel_n = 1'h0;
    tick(4);
  endtask : b_open
  task automatic b_close();
    tick(4);
    link_b.sel_n = 1'h1;
    link_b.serial_data_in = ~link_b.serial_data_in;
    tick(8);
  endtask : b_close

  // whole frame on link_b: instruction, address, one data byte
  task automatic b_frame(input logic op, input logic [7:0] c, input logic [23:0] a,
    input logic [7:0] d, output logic [7:0] r, output logic e);
    if (op) b_open();
    b_byte(c, r);
    b_byte(a[23:16], r);
    b_byte(a[15:8], r);
    b_byte(a[7:0], r);
    b_byte(d, r);
    e = link_b.dev_oe;
    b_close();
  endtask : b_frame

  // free-running system clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // cut a hang short
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("unexpected at %0t ns: got %0h expected %0h", $time, 0, 1);
    tally_and_finish();
  end

  // main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    rst_n = 1'h0;
    {req_valid, req_prog, wr_valid, rd_ready} = 4'h0;
    req_addr = '0;
    req_len = '0;
    wr_data = '0;
    link_b.serial_clock = 1'h0;
    link_b.sel_n = 1'h0; // low from reset on, so no select fall yet
    link_b.serial_data_in = 1'h0;
    tick(5);
    rst_n = 1'h1;
    // activity before the first select fall is ignored
    b_frame(1'h0, CMD_READ, 24'h000005, 8'h00, q, oe);
    `CHK(oe, 1'h0)
    `CHK(b_armed, 1'h0)
    // select fall arms and enables the device, then program a byte
    b_open();
    `CHK(b_active, 1'h1)
    `CHK(b_armed, 1'h1)
    b_frame(1'h0, CMD_PROG, 24'h000005, 8'h5A, q, oe);
    // partial byte dropped by deselect
    b_open();
    repeat (3) b_bit(1'h1, q[0]);
    b_close();
    b_frame(1'h1, CMD_READ, 24'h000005, 8'hFF, q, oe);
    `CHK(q, 8'h5A)
    `CHK(oe, 1'h1)
    `CHK(link_b.dev_oe, 1'h0)
    `CHK(link_b.master_serial_in, 1'h1)
    // master and flash joined: erased array reads ones
    m_req(1'h0, 24'h000010, 16'h0002);
    m_read(8'hFF);
    m_read(8'hFF);
    // program two bytes, then clear more bits of the first
    m_req(1'h1, 24'h000100, 16'h0002);
    m_write(8'hA5);
    m_write(8'h3C);
    m_req(1'h1, 24'h000100, 16'h0001);
    m_write(8'hF0);
    // last location and wrap back to the first
    m_req(1'h1, 24'(TOP_A), 16'h0001);
    m_write(8'h81);
    m_req(1'h0, 24'(TOP_A), 16'h0002);
    m_read(8'h81);
    m_read(8'hFF);
    m_req(1'h0, 24'h000100 + 24'(MEM_B / 8), 16'h0001);
    m_read(8'hA0);
    // long read with the drain side stalled: frame held open, clock parked
    m_req(1'h0, 24'h000100, 16'h0006);
    tick(2500);
    `CHK(link_a.sel_n, 1'h0)
    `CHK(link_a.serial_clock, 1'h0)
    `CHK(rd_valid, 1'h1)
    for (int i = 0; i < 6; i++) m_read(EXP6[47 - 8 * i -: 8]);
    tick(100);
    tally_and_finish();
  end
endmodule : tb_top
